// ==== include/wapt_pkg.sv ====
// Constants for the wrapping absolute position tracker
package wapt_pkg;
    // ============================================================
    // Object map
    localparam logic [15:0] OBJ_HOME_OFFSET = 16'h607c;
    localparam logic [31:0] HOME_OFFSET_RST = 32'h0000_0000;
    // ============================================================
    // Encoder and settings
    localparam int          ST_BITS         = 23;
    localparam int          MT_BITS         = 16;
    localparam int          GEAR_BITS       = 16;
    localparam logic [3:0]  MODE_CONT       = 4'h4;
    localparam logic [15:0] LIMIT_FULL      = 16'hffff;
    localparam logic [63:0] POS_CEIL        = 64'h0000_0000_8000_0000;
    // Later releases check unreachable targets; earliest did not
    localparam logic        TARGET_CHECK_EN = 1'b1;
    typedef logic signed [63:0] wapt_wide_t;
endpackage

// ==== include/wapt_turn_if.sv ====
// Signals between the tracker and its turn counter
`timescale 1ns/1ps
interface wapt_turn_if;
    logic [22:0] stCount;
    logic [15:0] mtLoad;
    logic        load;
    logic [15:0] limit;
    logic [15:0] mtCount;
    modport ctr  (input stCount, input mtLoad, input load, input limit, output mtCount);
    modport user (output stCount, output mtLoad, output load, output limit, input mtCount);
endinterface // wapt_turn_if

// ==== logic/wapt_turn_counter.sv ====
// Multi-turn counter that wraps at the effective upper limit
`timescale 1ns/1ps
module wapt_turn_counter (
    input  wire logic   clk_sys,
    input  wire logic   arst_n,
    wapt_turn_if.ctr    turn
);
    import wapt_pkg::*;

    logic [22:0] stPrev_r;
    logic [15:0] mt_r;
    logic        up;
    logic        down;

    // Crossing of the single-turn zero point
    assign up   = (stPrev_r[22:21] == 2'b11) && (turn.stCount[22:21] == 2'b00);
    assign down = (stPrev_r[22:21] == 2'b00) && (turn.stCount[22:21] == 2'b11);
    assign turn.mtCount = mt_r;

    // Previous single-turn sample
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stPrev_r <= 23'h000000;
        end else begin
            stPrev_r <= turn.stCount;
        end
    end

    // Turn count with wrap in both directions
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mt_r <= 16'h0000;
        end else if (turn.load) begin
            mt_r <= (turn.mtLoad > turn.limit) ? turn.limit : turn.mtLoad;
        end else if (up) begin
            mt_r <= (mt_r >= turn.limit) ? 16'h0000 : mt_r + 16'h0001;
        end else if (down) begin
            mt_r <= (mt_r == 16'h0000) ? turn.limit : mt_r - 16'h0001;
        end
    end
endmodule // wapt_turn_counter

// ==== logic/wapt_tracker.sv ====
// Wrapping absolute position tracker, top level
`timescale 1ns/1ps
module wapt_tracker (
    input  wire logic                           clk_sys,
    input  wire logic                           arst_n,
    // Object access
    input  wire logic                           objWrEn,
    input  wire logic [15:0]                    objAddr,
    input  wire logic [31:0]                    objWrData,
    output logic      [31:0]                    objRdData,
    // Power-cycle class settings; mode, upper limit and gear pend until apply, polarity and range limits act at once
    input  wire logic [3:0]                     absolute_encoder_mode_select,
    input  wire logic [15:0]                    multiturn_upper_limit,
    input  wire logic [wapt_pkg::GEAR_BITS-1:0] gearInverse,
    input  wire logic                           position_polarity,
    input  wire logic signed [31:0]             position_range_limit_min,
    input  wire logic signed [31:0]             position_range_limit_max,
    input  wire logic                           configEnable,
    // Events
    input  wire logic                           fbInitToPreop,
    input  wire logic                           mtClear,
    input  wire logic                           toolOpDone,
    input  wire logic                           homingDone,
    input  wire logic [wapt_pkg::ST_BITS-1:0]   indexSt,
    input  wire logic [wapt_pkg::MT_BITS-1:0]   indexMt,
    // Encoder side
    input  wire logic [wapt_pkg::ST_BITS-1:0]   encSt,
    input  wire logic [wapt_pkg::MT_BITS-1:0]   encMt,
    input  wire logic [15:0]                    encLimitStored,
    output logic                                encLimitWr,
    output logic      [15:0]                    encLimitData,
    // Target check
    input  wire logic                           targetValid,
    input  wire logic signed [31:0]             targetPos,
    input  wire logic                           targetCheckMode,
    // Results
    output logic signed [31:0]                  actualPos,
    output logic                                wrapActive,
    output logic                                command_error_fault,
    output logic                                parameter_setting_fault,
    output logic                                upper_limit_mismatch_fault,
    input  wire logic                           faultClear
);
    import wapt_pkg::*;

    // ============================================================
    // Storage
    logic        [31:0]          homeOffset_r;
    logic        [3:0]           modeEff_r;
    logic        [15:0]          limitEff_r;
    logic        [GEAR_BITS-1:0] gearEff_r;
    logic                        applyPend_r;
    logic                        presetPend_r;
    logic                        offsetChk_r;
    wapt_wide_t                  posBase_r;
    logic signed [31:0]          actualPos_r;
    logic        [31:0]          objRdData_r;
    logic                        encLimitWr_r;
    logic        [15:0]          encLimitData_r;
    logic                        cmdErr_r;
    logic                        parErr_r;
    logic                        mismatch_r;
    logic                        wrapActive_r;

    logic                        apply;
    logic                        preset;
    logic                        active;
    logic        [15:0]          limitUse;
    wapt_wide_t                  span;
    wapt_wide_t                  scaledNow;
    wapt_wide_t                  scaledIdx;
    wapt_wide_t                  posSum;
    wapt_wide_t                  posWrap;
    wapt_wide_t                  offsetW;
    wapt_wide_t                  targetW;
    logic                        overflow;
    logic                        offsetBad;
    logic                        targetBad;

    wapt_turn_if turn ();

    wapt_turn_counter u_turn (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .turn    (turn.ctr)
    );

    // ============================================================
    // Effective settings
    assign apply    = applyPend_r | configEnable;
    assign active   = (modeEff_r == MODE_CONT);
    assign limitUse = !active ? LIMIT_FULL
                    : (limitEff_r == 16'h0000) ? 16'h0001 : limitEff_r;

    // Power-on sample after release, or on configuration enable
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            applyPend_r <= 1'b1;
            modeEff_r   <= 4'h0;
            limitEff_r  <= 16'h0000;
            gearEff_r   <= '0;
            wrapActive_r <= 1'b0;
        end else begin
            applyPend_r <= 1'b0;
            if (apply) begin
                modeEff_r  <= absolute_encoder_mode_select;
                wrapActive_r <= (absolute_encoder_mode_select == MODE_CONT);
                limitEff_r <= multiturn_upper_limit;
                gearEff_r  <= gearInverse;
            end
        end
    end

    // Turn counter feed, reloaded from the encoder the cycle after apply, zeroed on mtClear
    assign turn.stCount = encSt;
    assign turn.mtLoad  = mtClear ? 16'h0000 : encMt;
    assign turn.load    = presetPend_r | mtClear;
    assign turn.limit   = limitUse;

    // ============================================================
    // Scaling and wrap
    function automatic wapt_wide_t scale(input logic [15:0] mt, input logic [22:0] st,
                                         input logic pol, input wapt_wide_t sp);
        wapt_wide_t raw;
        raw = wapt_wide_t'({mt, st}) * wapt_wide_t'(gearEff_r);
        scale = pol ? ((raw == 64'sd0) ? 64'sd0 : sp - raw) : raw;
    endfunction

    assign span      = (wapt_wide_t'(limitUse) + 64'sd1) * wapt_wide_t'(gearEff_r)
                       <<< ST_BITS;
    assign scaledNow = scale(turn.mtCount, encSt, position_polarity, span);
    assign scaledIdx = scale(indexMt, indexSt, position_polarity, span);
    assign posSum    = scaledNow + posBase_r;
    // Single correction suffices: base stays within one span
    assign posWrap   = (posSum >= span) ? posSum - span
                     : (posSum < 64'sd0) ? posSum + span : posSum;
    assign offsetW   = wapt_wide_t'($signed(homeOffset_r));
    assign targetW   = wapt_wide_t'(targetPos);

    // ============================================================
    // Checks
    assign overflow  = active && ((span - wapt_wide_t'(gearEff_r)) > $signed(POS_CEIL));
    // Top of the offset range is one gear step below the span
    assign offsetBad = active && ((offsetW < 64'sd0)
                     || (offsetW > span - wapt_wide_t'(gearEff_r)));
    assign targetBad = (targetW < 64'sd0) || (targetW > span - 64'sd1)
                     || (targetPos < position_range_limit_min)
                     || (targetPos > position_range_limit_max);

    // ============================================================
    // Home offset object and read-back
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            homeOffset_r <= HOME_OFFSET_RST;
            offsetChk_r  <= 1'b0;
        end else begin
            offsetChk_r <= objWrEn && (objAddr == OBJ_HOME_OFFSET);
            if (objWrEn && (objAddr == OBJ_HOME_OFFSET)) begin
                homeOffset_r <= objWrData;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            objRdData_r <= 32'h0000_0000;
        end else begin
            objRdData_r <= (objAddr == OBJ_HOME_OFFSET) ? homeOffset_r : 32'h0000_0000;
        end
    end

    // ============================================================
    // Preset and homing base
    assign preset = presetPend_r | fbInitToPreop | mtClear | toolOpDone;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            presetPend_r <= 1'b0;
        end else begin
            presetPend_r <= apply;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            posBase_r <= 64'sd0;
        end else if (homingDone) begin
            posBase_r <= offsetW - scaledIdx;
        end else if (preset) begin
            posBase_r <= offsetW;
        end
    end

    // Actual position
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            actualPos_r <= 32'sh0000_0000;
        end else begin
            actualPos_r <= posWrap[31:0];
        end
    end

    // ============================================================
    // Encoder limit write after an apply, at startup or on configuration enable, in wrap mode when the stored limit differs, and mismatch
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            encLimitWr_r   <= 1'b0;
            encLimitData_r <= 16'h0000;
        end else begin
            encLimitWr_r <= presetPend_r && active && (encLimitStored != limitEff_r);
            if (presetPend_r) begin
                encLimitData_r <= limitEff_r;
            end
        end
    end

    // ============================================================
    // Sticky faults, a new event wins over a clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mismatch_r <= 1'b0;
        end else if (presetPend_r && active && (encLimitStored != limitEff_r)) begin
            mismatch_r <= 1'b1;
        end else if (faultClear) begin
            mismatch_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            parErr_r <= 1'b0;
        end else if ((presetPend_r || offsetChk_r) && (overflow || offsetBad)) begin
            parErr_r <= 1'b1;
        end else if (faultClear) begin
            parErr_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cmdErr_r <= 1'b0;
        end else if (TARGET_CHECK_EN && active && targetValid && targetCheckMode
                     && targetBad) begin
            cmdErr_r <= 1'b1;
        end else if (faultClear) begin
            cmdErr_r <= 1'b0;
        end
    end

    // ============================================================
    // Outputs
    assign objRdData                  = objRdData_r;
    assign encLimitWr                 = encLimitWr_r;
    assign encLimitData               = encLimitData_r;
    assign actualPos                  = actualPos_r;
    assign wrapActive                 = wrapActive_r;
    assign command_error_fault        = cmdErr_r;
    assign parameter_setting_fault    = parErr_r;
    assign upper_limit_mismatch_fault = mismatch_r;
endmodule // wapt_tracker

// ==== tb/wapt_tracker_checker.sv ====
// Assertion checker for the wrapping absolute position tracker
`timescale 1ns/1ps
module wapt_tracker_checker (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        objWrEn,
    input wire logic        configEnable,
    input wire logic        targetValid,
    input wire logic        targetCheckMode,
    input wire logic        faultClear,
    input wire logic [15:0] encLimitStored,
    input wire logic        encLimitWr,
    input wire logic [15:0] encLimitData,
    input wire logic        wrapActive,
    input wire logic        command_error_fault,
    input wire logic        parameter_setting_fault,
    input wire logic        upper_limit_mismatch_fault
);
    logic [2:0] quiet_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // ============================================================
    // Cycles since the last object write or apply, saturating
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) quiet_r <= 3'h0;
        else if (objWrEn || configEnable) quiet_r <= 3'h0;
        else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
    end
    // ============================================================
    // Fault causes and persistence
    AST_CMD_CAUSE: assert property ($rose(command_error_fault) |->
        $past(targetValid) || $past(targetValid, 2)) else $error("command fault without target");
    AST_CMD_MODE: assert property ($rose(command_error_fault) |->
        wrapActive && $past(targetCheckMode)) else $error("command fault outside wrap mode");
    AST_WR_DIFF: assert property (encLimitWr |->
        wrapActive && encLimitData != encLimitStored) else $error("needless encoder write");
    AST_WR_PULSE: assert property (encLimitWr |=> !encLimitWr)
        else $error("encoder write longer than a cycle");
    AST_MIS_WR: assert property ($rose(upper_limit_mismatch_fault) |->
        encLimitWr || $past(encLimitWr)) else $error("mismatch without encoder write");
    AST_MIS_HOLD: assert property (upper_limit_mismatch_fault && !faultClear |=>
        upper_limit_mismatch_fault) else $error("mismatch fault dropped");
    AST_PAR_CAUSE: assert property ($rose(parameter_setting_fault) |->
        quiet_r <= 3'h4) else $error("setting fault without new settings");
    AST_PAR_HOLD: assert property (parameter_setting_fault && !faultClear |=>
        parameter_setting_fault) else $error("setting fault dropped");
    AST_WRAP_APPLY: assert property ($changed(wrapActive) |-> quiet_r <= 3'h2)
        else $error("wrap mode changed without apply");
    cover property ($rose(encLimitWr));
    cover property ($rose(command_error_fault));
    cover property ($rose(parameter_setting_fault));
endmodule // wapt_tracker_checker

bind wapt_tracker wapt_tracker_checker wapt_tracker_checker_inst (
    .clk_sys, .arst_n, .objWrEn, .configEnable, .targetValid, .targetCheckMode, .faultClear,
    .encLimitStored, .encLimitWr, .encLimitData, .wrapActive, .command_error_fault,
    .parameter_setting_fault, .upper_limit_mismatch_fault
);

// ==== tb/wapt_host_model.sv ====
// Host controller model issuing object accesses and target commands
`timescale 1ns/1ps
module wapt_host_model (
    input  wire logic               clk_sys,
    output logic                    objWrEn,
    output logic [15:0]             objAddr,
    output logic [31:0]             objWrData,
    input  wire logic [31:0]        objRdData,
    output logic                    targetValid,
    output logic signed [31:0]      targetPos,
    input  wire logic signed [31:0] actualPos
);
    logic signed [31:0] cmdPos;
    // Idle bus at time zero
    initial begin
        objWrEn = 1'h0;
        objAddr = 16'h0000;
        objWrData = 32'h0;
        targetValid = 1'h0;
        targetPos = 32'h0;
        cmdPos = 32'h0;
    end
    // One object write; released data shows its inverse
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        #1;
        objWrEn = 1'h1;
        objAddr = a;
        objWrData = d;
        @(posedge clk_sys);
        #1;
        objWrEn = 1'h0;
        objWrData = ~d;
    endtask
    // Read answers one cycle after the index
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        #1;
        objAddr = a;
        @(posedge clk_sys);
        #1;
        d = objRdData;
    endtask
    // Command position starts from the actual position
    task automatic initCmd;
        cmdPos = actualPos;
    endtask
    // One target command, released value inverted
    task automatic target(input logic signed [31:0] p);
        @(posedge clk_sys);
        #1;
        targetValid = 1'h1;
        targetPos = p;
        @(posedge clk_sys);
        #1;
        targetValid = 1'h0;
        targetPos = ~p;
    endtask
endmodule // wapt_host_model

// ==== tb/wapt_tracker_tb.sv ====
// Self-checking testbench for the wrapping absolute position tracker
`timescale 1ns/1ps
module wapt_tracker_tb;
    import wapt_pkg::*;
    localparam logic [15:0] LIM  = 16'h0002;      // Ratio denominator 3, minus one
    localparam logic [31:0] SPAN = 32'h0180_0000; // Three turns of 2^23 steps
    localparam logic [31:0] RAW  = 32'h0080_0005; // Turn 1, step 5
    localparam logic [5:0]  CFG = 6'h20, PRE = 6'h10, MTC = 6'h08, TOOL = 6'h04;
    localparam logic [5:0]  HOME = 6'h02, CLR = 6'h01;
    logic        clk_sys = 1'h0;
    logic        arst_n = 1'h0;
    logic        objWrEn, targetValid, encLimitWr, wrapActive, position_polarity, targetCheckMode;
    logic        command_error_fault, parameter_setting_fault, upper_limit_mismatch_fault;
    logic        configEnable, fbInitToPreop, mtClear, toolOpDone, homingDone, faultClear;
    logic [5:0]  ev = 6'h00;
    logic [3:0]  absolute_encoder_mode_select;
    logic [15:0] objAddr, multiturn_upper_limit, encLimitStored, encLimitData, encMt, indexMt;
    logic [15:0] gearInverse;
    logic [22:0] encSt, indexSt;
    logic [31:0] objWrData, objRdData;
    logic signed [31:0] position_range_limit_min, position_range_limit_max, targetPos, actualPos;
    int          badCount = 0;
    int          checkCount = 0;
    int          cycles = 0;
    assign {configEnable, fbInitToPreop, mtClear, toolOpDone, homingDone, faultClear} = ev;
    wapt_tracker wapt_tracker_inst (.clk_sys, .arst_n, .objWrEn, .objAddr, .objWrData,
        .objRdData, .absolute_encoder_mode_select, .multiturn_upper_limit,
        .gearInverse, .position_polarity, .position_range_limit_min,
        .position_range_limit_max, .configEnable, .fbInitToPreop, .mtClear, .toolOpDone,
        .homingDone, .indexSt, .indexMt, .encSt, .encMt, .encLimitStored, .encLimitWr,
        .encLimitData, .targetValid, .targetPos, .targetCheckMode, .actualPos, .wrapActive,
        .command_error_fault, .parameter_setting_fault, .upper_limit_mismatch_fault,
        .faultClear);
    wapt_host_model wapt_host_model_inst (.clk_sys, .objWrEn, .objAddr, .objWrData,
        .objRdData, .targetValid, .targetPos, .actualPos);
    // Clock, battery-backed encoder limit, hang guard
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (encLimitWr) encLimitStored <= encLimitData;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            badCount++;
            summarize();
        end
    end
    task automatic summarize;
        if (badCount == 0 && checkCount > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            badCount++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(input logic [5:0] m);
        ev = m;
        cyc(1);
        ev = 6'h00;
    endtask
    // ============================================================
    // Scenarios
    task automatic scnStartup;
        logic [31:0] d;
        wapt_host_model_inst.rd(OBJ_HOME_OFFSET, d);
        chk("offset reset", d, HOME_OFFSET_RST);
        wapt_host_model_inst.rd(16'h607b, d);
        chk("unmapped read", d, 32'h0);
        chk("wrap active", 32'(wrapActive), 32'h1);
        chk("encoder limit", 32'(encLimitStored), 32'(LIM));
        chk("mismatch", 32'(upper_limit_mismatch_fault), 32'h1);
        chk("power-on pos", actualPos, RAW);
    endtask
    task automatic scnPolarity;
        position_polarity = 1'h1;
        cyc(3);
        chk("reversed pos", actualPos, SPAN - RAW);
        position_polarity = 1'h0;
        cyc(3);
        chk("forward pos", actualPos, RAW);
    endtask
    task automatic scnPresets;
        logic [5:0] evs [3] = '{PRE, MTC, TOOL};
        logic [31:0] d;
        for (int i = 0; i < 3; i++) begin
            wapt_host_model_inst.wr(OBJ_HOME_OFFSET, 32'(1000 * (i + 1)));
            if (evs[i] == MTC) encMt = 16'h0000;
            pulse(evs[i]);
            cyc(3);
            chk("preset pos", actualPos, (i > 0 ? 32'h5 : RAW) + 32'(1000 * (i + 1)));
        end
        wapt_host_model_inst.wr(16'h607b, 32'h0000_1234);
        wapt_host_model_inst.rd(OBJ_HOME_OFFSET, d);
        chk("stray write", d, 32'h0000_0bb8);
    endtask
    // Turn crossings downward past zero and upward past the limit
    task automatic scnWrap;
        encSt = 23'h7f_ffff;
        cyc(3);
        chk("wrap down", actualPos, 32'h0000_0bb7);
        encSt = 23'h00_0005;
        cyc(3);
        chk("wrap up", actualPos, 32'h0000_0bbd);
    endtask
    task automatic scnHoming;
        wapt_host_model_inst.wr(OBJ_HOME_OFFSET, 32'h0000_2710);
        indexSt = encSt;
        indexMt = encMt;
        pulse(HOME | PRE);
        cyc(3);
        chk("homed pos", actualPos, 32'h0000_2710);
    endtask
    task automatic scnOffset;
        logic [31:0] v [3] = '{SPAN - 32'h1, SPAN, 32'hffff_ffff};
        for (int i = 0; i < 3; i++) begin
            pulse(CLR);
            wapt_host_model_inst.wr(OBJ_HOME_OFFSET, v[i]);
            cyc(3);
            chk("offset fault", 32'(parameter_setting_fault), 32'(i != 0));
        end
        wapt_host_model_inst.wr(OBJ_HOME_OFFSET, 32'h0);
        pulse(CLR);
    endtask
    task automatic scnTarget;
        logic [31:0] p [4] = '{32'h0000_03e8, SPAN, 32'h0140_0000, SPAN};
        position_range_limit_max = 32'h0130_0000;
        wapt_host_model_inst.initCmd();
        chk("command init", wapt_host_model_inst.cmdPos, 32'h0000_2710);
        for (int i = 0; i < 4; i++) begin
            pulse(CLR);
            targetCheckMode = (i != 3);
            wapt_host_model_inst.target(p[i]);
            cyc(3);
            chk("target fault", 32'(command_error_fault), 32'(i == 1 || i == 2));
        end
    endtask
    task automatic scnApply;
        logic [15:0] lim [4] = '{LIM, 16'h0100, 16'h00ff, 16'h0000};
        for (int i = 0; i < 4; i++) begin
            multiturn_upper_limit = lim[i];
            pulse(CLR);
            pulse(CFG);
            cyc(4);
            if (i == 0) chk("mismatch gone", 32'(upper_limit_mismatch_fault), 32'h0);
            if (i != 3) chk("overflow", 32'(parameter_setting_fault), 32'(i == 1));
        end
        pulse(CLR);
        wapt_host_model_inst.wr(OBJ_HOME_OFFSET, 32'h00ff_ffff);
        cyc(3);
        chk("limit zero top", 32'(parameter_setting_fault), 32'h0);
        wapt_host_model_inst.wr(OBJ_HOME_OFFSET, 32'h0100_0000);
        cyc(3);
        chk("limit zero over", 32'(parameter_setting_fault), 32'h1);
        gearInverse = 16'h0002;
        pulse(CLR);
        pulse(CFG);
        for (int i = 0; i < 2; i++) begin
            wapt_host_model_inst.wr(OBJ_HOME_OFFSET, 32'h01ff_fffe + 32'(i));
            cyc(3);
            chk("geared offset", 32'(parameter_setting_fault), 32'(i));
        end
    endtask
    task automatic scnMode0;
        absolute_encoder_mode_select = 4'h0;
        pulse(CFG);
        cyc(4);
        pulse(CLR);
        chk("wrap off", 32'(wrapActive), 32'h0);
        targetCheckMode = 1'h1;
        wapt_host_model_inst.target(SPAN);
        cyc(3);
        chk("no target check", 32'(command_error_fault), 32'h0);
    endtask
    // Reset for eight cycles, then run every scenario
    initial begin
        absolute_encoder_mode_select = MODE_CONT;
        multiturn_upper_limit = LIM;
        gearInverse = 16'h0001;
        position_polarity = 1'h0;
        position_range_limit_min = 32'h0;
        position_range_limit_max = 32'h7fff_ffff;
        targetCheckMode = 1'h1;
        encSt = 23'h5;
        encMt = 16'h0001;
        indexSt = 23'h0;
        indexMt = 16'h0000;
        encLimitStored = 16'h0000;
        cyc(8);
        arst_n = 1'h1;
        cyc(3);
        scnStartup();
        scnPolarity();
        scnPresets();
        scnWrap();
        scnHoming();
        scnOffset();
        scnTarget();
        scnApply();
        scnMode0();
        summarize();
    end
endmodule // wapt_tracker_tb
